// >>> rtl/pm_event_route_cstate_ctrl.sv
// Summary of operation
// - events to firmware or os per select
// - native-only build: select reads one always
// - os interrupt shareable, active-low level
// - command port write of enable or disable value raises firmware event
// - firmware acknowledges by setting or clearing select
// - c1 entered by processor halt alone
// - level reads enter c2 or c3 exactly
// - c2 keeps snoop enabled
// - interrupt or reset leaves c2
// - c3 keeps cache, snoop off
// - c3 bus request wakes, re-enables masters
// - bus master active flag provided
// - wake enable gates bus master exit
// - idle states only in working state
`timescale 1ns/10ps
`default_nettype none
`include "pm_route_consts.svh"
module pm_event_route_cstate_ctrl #(
	parameter bit LEGACY_SUPPORTED = 1'b1
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	// pm events
	input  wire logic [`EVENT_WIDTH-1:0]   pm_events,
	// mode command port
	input  wire logic                      cmd_wr,
	input  wire logic [`CMD_WIDTH-1:0]     cmd_data,
	// firmware acknowledge of mode switch
	input  wire logic                      fw_route_set,
	input  wire logic                      fw_route_clear,
	// routing select status
	output logic                           event_route_select,
	// interrupts
	output logic                           firmware_mgmt_interrupt,
	output logic                           os_visible_pm_interrupt_b,
	output logic                           mode_switch_event,
	// per cpu power block reads
	input  wire logic                      level2_rd,
	input  wire logic                      level3_rd,
	output logic                           entry_rd_ack,
	output logic [7:0]                     entry_rd_data,
	// processor complex
	input  wire logic                      halt_exec,
	input  wire logic                      irq_req,
	input  wire logic                      sys_working,
	output pm_route_pkg::cstate_type       cpu_cstate,
	output logic                           snoop_enable,
	// bus masters
	input  wire logic                      bm_req,
	input  wire logic                      bm_active,
	input  wire logic                      bm_flag_clear,
	input  wire logic                      arbiter_disable_wr,
	input  wire logic                      arbiter_disable_in,
	input  wire logic                      bus_master_wake_enable,
	output logic                           bus_master_active_flag,
	output logic                           arbiter_disable
);
	import pm_route_pkg::*;

	////////////////////////////////////////////////////////////////
	// routing select and command port

	logic route_reg;
	logic route_next;
	logic sw_ev_reg;
	logic sw_ev_next;
	logic fw_irq;
	logic os_irq;

	always_comb begin
		route_next = route_reg;
		if (fw_route_set)
			route_next = 1'b1;
		else if (fw_route_clear)
			route_next = 1'b0;
		if (!LEGACY_SUPPORTED)
			route_next = 1'b1;
		sw_ev_next = cmd_wr && LEGACY_SUPPORTED &&
			(cmd_data == `NATIVE_ENABLE_VALUE_DEF || cmd_data == `NATIVE_DISABLE_VALUE_DEF);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			route_reg <= `ROUTE_SELECT_RESET | ~LEGACY_SUPPORTED;
			sw_ev_reg <= 1'b0;
		end else begin
			route_reg <= route_next;
			sw_ev_reg <= sw_ev_next;
		end
	end

	event_router u_router (
		.clk          (clk),
		.rst_b        (rst_b),
		.route_select (route_reg | ~LEGACY_SUPPORTED),
		.events       (pm_events),
		.fw_irq       (fw_irq),
		.os_irq       (os_irq)
	);

	////////////////////////////////////////////////////////////////
	// idle state control

	idle_link_if lnk ();
	logic bm_flag_reg;
	logic bm_flag_next;
	logic arb_reg;
	logic arb_next;

	assign lnk.enter_c2 = level2_rd;
	assign lnk.enter_c3 = level3_rd;

	idle_state_ctrl u_idle (
		.clk         (clk),
		.rst_b       (rst_b),
		.lnk         (lnk),
		.halt_exec   (halt_exec),
		.irq_req     (irq_req),
		.bm_req      (bm_req),
		.bm_wake_en  (bus_master_wake_enable),
		.sys_working (sys_working)
	);

	// sticky activity flag; set wins over clear
	always_comb begin
		bm_flag_next = bm_active | (bm_flag_reg & ~bm_flag_clear);
		arb_next = arb_reg;
		if (arbiter_disable_wr)
			arb_next = arbiter_disable_in;
		if (lnk.arb_off)
			arb_next = 1'b0;
	end

	// outputs registered from internal state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bm_flag_reg               <= 1'b0;
			arb_reg                   <= 1'b0;
			event_route_select        <= `ROUTE_SELECT_RESET | ~LEGACY_SUPPORTED;
			firmware_mgmt_interrupt   <= 1'b0;
			os_visible_pm_interrupt_b <= 1'b1;
			mode_switch_event         <= 1'b0;
			entry_rd_ack              <= 1'b0;
			entry_rd_data             <= 8'h00;
			cpu_cstate                <= CST_C0;
			snoop_enable              <= 1'b1;
		end else begin
			bm_flag_reg               <= bm_flag_next;
			arb_reg                   <= arb_next;
			event_route_select        <= route_reg | ~LEGACY_SUPPORTED;
			firmware_mgmt_interrupt   <= fw_irq | sw_ev_reg;
			os_visible_pm_interrupt_b <= ~os_irq;
			mode_switch_event         <= sw_ev_reg;
			entry_rd_ack              <= level2_rd | level3_rd;
			entry_rd_data             <= 8'h00;
			cpu_cstate                <= lnk.cstate;
			snoop_enable              <= (lnk.cstate != CST_C3);
		end
	end

	assign bus_master_active_flag = bm_flag_reg;
	assign arbiter_disable        = arb_reg;

	////////////////////////////////////////////////////////////////
	// checks

	cmd_event_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd_wr && cmd_data == `NATIVE_ENABLE_VALUE_DEF && LEGACY_SUPPORTED) |=> ##1 mode_switch_event)
		else $error("command write raised no event");
	route_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
		fw_route_set |=> ##1 event_route_select)
		else $error("select not set on acknowledge");
	route_wired_a: assert property (@(posedge clk) disable iff (!rst_b)
		!LEGACY_SUPPORTED |-> event_route_select)
		else $error("select not wired to one");
	snoop_c3_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cpu_cstate == CST_C3) |-> !snoop_enable)
		else $error("snoop enabled in c3");
	bm_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		bm_active |=> bus_master_active_flag)
		else $error("activity flag not set");
	entry_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
		level2_rd |=> entry_rd_ack)
		else $error("entry read not acknowledged");
	working_only_a: assert property (@(posedge clk) disable iff (!rst_b)
		!sys_working |=> ##1 cpu_cstate == CST_C0)
		else $error("idle state outside working state");

	legacy_route_a: assert property (@(posedge clk) disable iff (!rst_b)
		((|pm_events) && !(route_reg | ~LEGACY_SUPPORTED)) |=> ##1 firmware_mgmt_interrupt)
		else $error("legacy event missed firmware interrupt");

	native_route_a: assert property (@(posedge clk) disable iff (!rst_b)
		((|pm_events) && (route_reg | ~LEGACY_SUPPORTED)) |=> ##1 !os_visible_pm_interrupt_b)
		else $error("native event missed os interrupt");

	os_release_a: assert property (@(posedge clk) disable iff (!rst_b)
		!(|pm_events) |=> ##1 os_visible_pm_interrupt_b)
		else $error("os interrupt held without event");

	route_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!fw_route_set && !fw_route_clear) |=> $stable(route_reg))
		else $error("select changed without firmware");

	route_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		(fw_route_clear && !fw_route_set && LEGACY_SUPPORTED) |=> ##1 !event_route_select)
		else $error("select not cleared on acknowledge");

	cmd_disable_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd_wr && cmd_data == `NATIVE_DISABLE_VALUE_DEF && LEGACY_SUPPORTED) |=> ##1 mode_switch_event)
		else $error("disable write raised no event");

	cmd_ignore_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd_wr && cmd_data != `NATIVE_ENABLE_VALUE_DEF && cmd_data != `NATIVE_DISABLE_VALUE_DEF)
		|=> ##1 !mode_switch_event)
		else $error("event raised for unknown command");

	cmd_fw_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd_wr && cmd_data == `NATIVE_ENABLE_VALUE_DEF && LEGACY_SUPPORTED) |=> ##1 firmware_mgmt_interrupt)
		else $error("command write did not interrupt firmware");

	entry_ack3_a: assert property (@(posedge clk) disable iff (!rst_b)
		level3_rd |=> entry_rd_ack)
		else $error("level3 read not acknowledged");

	entry_data_a: assert property (@(posedge clk) disable iff (!rst_b)
		entry_rd_ack |-> entry_rd_data == 8'h00)
		else $error("entry read data not zero");

	enter_c3_a: assert property (@(posedge clk) disable iff (!rst_b)
		(lnk.cstate == CST_C0 && level3_rd && sys_working) |=> ##1 cpu_cstate == CST_C3)
		else $error("c3 not entered on read");

	halt_c1_a: assert property (@(posedge clk) disable iff (!rst_b)
		(lnk.cstate == CST_C0 && halt_exec && !level2_rd && !level3_rd && sys_working)
		|=> ##1 cpu_cstate == CST_C1)
		else $error("halt did not enter c1");

	c1_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
		(lnk.cstate == CST_C1 && irq_req) |=> ##1 cpu_cstate == CST_C0)
		else $error("interrupt did not exit c1");

	c2_bm_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
		(lnk.cstate == CST_C2 && bm_req && bus_master_wake_enable) |=> ##1 cpu_cstate == CST_C0)
		else $error("bus master request did not exit c2");

	snoop_c2_a: assert property (@(posedge clk) disable iff (!rst_b)
		(cpu_cstate == CST_C2) |-> snoop_enable)
		else $error("snoop disabled in c2");

	arb_rearm_a: assert property (@(posedge clk) disable iff (!rst_b)
		(lnk.cstate == CST_C3 && bm_req && bus_master_wake_enable && sys_working) |=> ##1 !arbiter_disable)
		else $error("arbiter still disabled after c3 wake");

	arb_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		(arbiter_disable_wr && !lnk.arb_off) |=> arbiter_disable == $past(arbiter_disable_in))
		else $error("arbiter disable write lost");

	flag_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		(bm_flag_clear && !bm_active) |=> !bus_master_active_flag)
		else $error("activity flag not cleared");

	flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(bus_master_active_flag && !bm_flag_clear) |=> bus_master_active_flag)
		else $error("activity flag dropped without clear");
endmodule
`default_nettype wire

// >>> common/pm_route_consts.svh
`ifndef PM_ROUTE_CONSTS_SVH
`define PM_ROUTE_CONSTS_SVH

// command port values that ask firmware to switch modes
`define NATIVE_ENABLE_VALUE_DEF   8'ha0
`define NATIVE_DISABLE_VALUE_DEF  8'ha1
// routing select reset value: legacy (clear)
`define ROUTE_SELECT_RESET        1'b0
// width of the command port data
`define CMD_WIDTH                 8
// width of the pm event vector
`define EVENT_WIDTH               4

`endif

// >>> common/pm_route_pkg.sv
`default_nettype none
package pm_route_pkg;
	// processor idle level
	typedef enum logic [3:0] {
		CST_C0 = 4'b0001,
		CST_C1 = 4'b0010,
		CST_C2 = 4'b0100,
		CST_C3 = 4'b1000
	} cstate_type;
endpackage
`default_nettype wire

// >>> common/idle_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// link between top and idle controller: entry pulses in, state and arbiter release out
interface idle_link_if;
	logic                      enter_c2;
	logic                      enter_c3;
	pm_route_pkg::cstate_type  cstate;
	logic                      arb_off;
	modport ctrl (input enter_c2, input enter_c3, output cstate, output arb_off);
	modport top  (output enter_c2, output enter_c3, input cstate, input arb_off);
endinterface
`default_nettype wire

// >>> rtl/event_router.sv
`timescale 1ns/10ps
`default_nettype none
`include "pm_route_consts.svh"
// steers pm events to firmware or os-visible interrupt
module event_router (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	// control
	input  wire logic                      route_select,
	input  wire logic [`EVENT_WIDTH-1:0]   events,
	// interrupts
	output logic                           fw_irq,
	output logic                           os_irq
);
	logic fw_next;
	logic os_next;

	// decoder on routing bit
	// route by select bit
	always_comb begin
		fw_next = (|events) & ~route_select;
		os_next = (|events) & route_select;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fw_irq <= 1'b0;
			os_irq <= 1'b0;
		end else begin
			fw_irq <= fw_next;
			os_irq <= os_next;
		end
	end

	route_fw_a: assert property (@(posedge clk) disable iff (!rst_b)
		((|events) && !route_select) |=> fw_irq && !os_irq)
		else $error("event not steered to firmware");
	route_os_a: assert property (@(posedge clk) disable iff (!rst_b)
		((|events) && route_select) |=> os_irq && !fw_irq)
		else $error("event not steered to os interrupt");
endmodule
`default_nettype wire

// >>> rtl/idle_state_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// idle state machine for one processor
module idle_state_ctrl (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_b,
	// entry triggers and state
	idle_link_if.ctrl  lnk,
	// halt entry and wake sources
	input  wire logic  halt_exec,
	input  wire logic  irq_req,
	input  wire logic  bm_req,
	input  wire logic  bm_wake_en,
	input  wire logic  sys_working
);
	import pm_route_pkg::*;

	cstate_type state_reg;
	cstate_type state_next;
	logic       arb_reg;
	logic       arb_next;
	logic       bm_wake;

	assign lnk.cstate  = state_reg;
	assign lnk.arb_off = arb_reg;

	assign bm_wake = bm_req & bm_wake_en;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CST_C0: begin
				if (lnk.enter_c3)
					state_next = CST_C3;
				else if (lnk.enter_c2)
					state_next = CST_C2;
				else if (halt_exec)
					state_next = CST_C1;
			end
			CST_C1, CST_C2: begin
				if (irq_req || bm_wake)
					state_next = CST_C0;
			end
			CST_C3: begin
				if (irq_req || bm_wake)
					state_next = CST_C0;
			end
			default: state_next = CST_C0;
		endcase
		if (!sys_working)
			state_next = CST_C0;
		// one-cycle pulse on leaving c3, drops the arbiter disable
		arb_next = (state_reg == CST_C3) && (state_next == CST_C0);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= CST_C0;
			arb_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			arb_reg   <= arb_next;
		end
	end

	enter_c2_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == CST_C0 && lnk.enter_c2 && !lnk.enter_c3 && sys_working)
		|=> state_reg == CST_C2)
		else $error("c2 not entered on read");
	bm_nowake_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == CST_C3 && bm_req && !bm_wake_en && !irq_req && sys_working)
		|=> state_reg == CST_C3)
		else $error("bus master woke with wake disabled");
	c2_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == CST_C2 && irq_req) |=> state_reg == CST_C0)
		else $error("interrupt did not exit c2");
	c3_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state_reg == CST_C3 && bm_wake && sys_working) |=> state_reg == CST_C0 && lnk.arb_off)
		else $error("c3 wake did not re-enable bus masters");
endmodule
`default_nettype wire

// >>> verif/fw_mode_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "pm_route_consts.svh"
// firmware side of the mode switch: answers command events after a delay
module fw_mode_model #(
	parameter int DELAY = 3
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// command port as seen by firmware
	input  wire logic        cmd_wr,
	input  wire logic [7:0]  cmd_data,
	input  wire logic        mode_switch_event,
	// acknowledge toward the routing select
	output logic             fw_route_set,
	output logic             fw_route_clear
);
	logic [7:0] last_cmd;
	int         cnt;

	// a slow handler is the normal case, so the answer is never immediate
	// firmware sets or clears select
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			last_cmd       <= 8'h00;
			cnt            <= 0;
			fw_route_set   <= 1'b0;
			fw_route_clear <= 1'b0;
		end else begin
			fw_route_set   <= 1'b0;
			fw_route_clear <= 1'b0;
			if (cmd_wr)
				last_cmd <= cmd_data;
			if (mode_switch_event)
				cnt <= DELAY;
			else if (cnt > 0)
				cnt <= cnt - 1;
			if (cnt == 1) begin
				fw_route_set   <= (last_cmd == `NATIVE_ENABLE_VALUE_DEF);
				fw_route_clear <= (last_cmd == `NATIVE_DISABLE_VALUE_DEF);
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/pm_event_route_cstate_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pm_route_consts.svh"
`define CHK(nm, exp, got) n_compared++; if ((got) !== (exp)) begin \
	$display("unexpected %s exp %h got %h", nm, exp, got); n_fail++; end
`define POLL(c) for (int i = 0; i < 20 && !(c); i++) @(negedge clk);
module pm_event_route_cstate_ctrl_tb;
	import pm_route_pkg::*;
	logic       clk, rst_b, cmd_wr, fw_set, fw_clr, sel, fw_irq, os_b, mse, l2, l3, ack;
	logic       halt, irq, work, snoop, bm_req, bm_act, bm_clr, arb_wr, arb_in, wake_en, bm_flag, arb;
	logic       sel_n;
	logic [3:0] ev;
	logic [7:0] cmd, rd_data;
	cstate_type cst;
	int         n_fail, n_compared, cycles, seen;

	pm_event_route_cstate_ctrl uut (.clk, .rst_b, .pm_events(ev), .cmd_wr, .cmd_data(cmd),
		.fw_route_set(fw_set), .fw_route_clear(fw_clr), .event_route_select(sel),
		.firmware_mgmt_interrupt(fw_irq), .os_visible_pm_interrupt_b(os_b), .mode_switch_event(mse),
		.level2_rd(l2), .level3_rd(l3), .entry_rd_ack(ack), .entry_rd_data(rd_data), .halt_exec(halt),
		.irq_req(irq), .sys_working(work), .cpu_cstate(cst), .snoop_enable(snoop), .bm_req,
		.bm_active(bm_act), .bm_flag_clear(bm_clr), .arbiter_disable_wr(arb_wr),
		.arbiter_disable_in(arb_in), .bus_master_wake_enable(wake_en),
		.bus_master_active_flag(bm_flag), .arbiter_disable(arb));
	// native-only build shares every input; only its select is watched
	pm_event_route_cstate_ctrl #(.LEGACY_SUPPORTED(1'b0)) uut_native (.clk, .rst_b, .pm_events(ev),
		.cmd_wr, .cmd_data(cmd), .fw_route_set(fw_set), .fw_route_clear(fw_clr),
		.event_route_select(sel_n), .firmware_mgmt_interrupt(), .os_visible_pm_interrupt_b(),
		.mode_switch_event(), .level2_rd(l2), .level3_rd(l3), .entry_rd_ack(), .entry_rd_data(),
		.halt_exec(halt), .irq_req(irq), .sys_working(work), .cpu_cstate(), .snoop_enable(), .bm_req,
		.bm_active(bm_act), .bm_flag_clear(bm_clr), .arbiter_disable_wr(arb_wr),
		.arbiter_disable_in(arb_in), .bus_master_wake_enable(wake_en),
		.bus_master_active_flag(), .arbiter_disable());
	fw_mode_model #(.DELAY(3)) fw (.clk, .rst_b, .cmd_wr, .cmd_data(cmd), .mode_switch_event(mse),
		.fw_route_set(fw_set), .fw_route_clear(fw_clr));

	// clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one command port write, watching for the firmware event
	task automatic cmd_write(input logic [7:0] v);
		cmd = v; cmd_wr = 1'b1; cyc(1); cmd_wr = 1'b0; seen = 0;
		for (int i = 0; i < 4; i++) begin
			seen = seen | mse; cyc(1);
		end
	endtask

	task automatic t_route;
		`CHK("sel_native", 1'b1, sel_n)
		ev = 4'h2; cyc(3);
		`CHK("fw_irq", 1'b1, fw_irq)
		`CHK("os_b", 1'b1, os_b)
		ev = 4'h0; cyc(3);
		`CHK("fw_irq", 1'b0, fw_irq)
		// software sequence: select reads clear first
		// check clear, enable, poll set
		`CHK("sel", 1'b0, sel)
		cmd_write(8'h55);
		`CHK("mse_bad", 0, seen)
		cmd_write(`NATIVE_ENABLE_VALUE_DEF);
		`CHK("mse", 1, seen)
		`POLL(sel === 1'b1)
		`CHK("sel", 1'b1, sel)
		ev = 4'h8; cyc(3);
		`CHK("os_b", 1'b0, os_b)
		`CHK("fw_irq", 1'b0, fw_irq)
		// select read set, disable, poll clear
		ev = 4'h0; cmd_write(`NATIVE_DISABLE_VALUE_DEF);
		`POLL(sel === 1'b0)
		`CHK("sel", 1'b0, sel)
		`CHK("sel_native", 1'b1, sel_n)
	endtask

	task automatic t_c2;
		l2 = 1'b1; cyc(1); l2 = 1'b0;
		`CHK("ack", 1'b1, ack)
		`CHK("rd_data", 8'h00, rd_data)
		`POLL(cst === CST_C2)
		`CHK("cst", CST_C2, cst)
		`CHK("snoop", 1'b1, snoop)
		irq = 1'b1; cyc(3); irq = 1'b0;
		`CHK("cst", CST_C0, cst)
	endtask

	task automatic t_c3;
		arb_in = 1'b1; arb_wr = 1'b1; cyc(1); arb_wr = 1'b0; cyc(1);
		`CHK("arb", 1'b1, arb)
		// no activity seen, promote to c3
		`CHK("bm_flag_c3", 1'b0, bm_flag)
		l2 = 1'b1; l3 = 1'b1; cyc(1); l2 = 1'b0; l3 = 1'b0; cyc(3);
		`CHK("cst", CST_C3, cst)
		`CHK("snoop", 1'b0, snoop)
		bm_req = 1'b1; cyc(6);
		`CHK("cst", CST_C3, cst)
		// wake enable gates bus master wake from c1, c2 and c3
		wake_en = 1'b1; cyc(3);
		`CHK("cst", CST_C0, cst)
		`CHK("arb", 1'b0, arb)
		bm_req = 1'b0; wake_en = 1'b0;
	endtask

	task automatic t_c1_flag;
		halt = 1'b1; cyc(1); halt = 1'b0; cyc(2);
		`CHK("cst", CST_C1, cst)
		work = 1'b0; cyc(3);
		`CHK("cst", CST_C0, cst)
		work = 1'b1; bm_act = 1'b1; cyc(1); bm_act = 1'b0; cyc(4);
		`CHK("bm_flag", 1'b1, bm_flag)
		bm_clr = 1'b1; cyc(1); bm_clr = 1'b0; cyc(2);
		`CHK("bm_flag", 1'b0, bm_flag)
	endtask

	// hang guard, well beyond the fewer than a hundred cycles the run needs
	initial begin
		cycles = 0;
		forever begin
			@(posedge clk);
			cycles++;
			if (cycles == 5000) begin
				n_fail++;
				summarize();
			end
		end
	end

	initial begin
		n_fail = 0; n_compared = 0; rst_b = 1'b0; ev = 4'h0; cmd_wr = 1'b0; cmd = 8'h00;
		l2 = 1'b0; l3 = 1'b0; halt = 1'b0; irq = 1'b0; work = 1'b1; bm_req = 1'b0; bm_act = 1'b0;
		bm_clr = 1'b0; arb_wr = 1'b0; arb_in = 1'b0; wake_en = 1'b0;
		cyc(10);
		rst_b = 1'b1;
		`CHK("cst_rst", CST_C0, cst)
		`CHK("os_b_rst", 1'b1, os_b)
		t_route();
		t_c2();
		t_c3();
		t_c1_flag();
		summarize();
	end
endmodule
`default_nettype wire
